// File: verilog/exv_regs.vh
// constants for the exception vectoring and interrupt flag block
`ifndef EXV_REGS_VH
`define EXV_REGS_VH
// ==================================================================
// register offsets (byte addresses, one 32-bit word each)
`define EXV_OFF_BASE      8'h00
`define EXV_OFF_CTRL      8'h04
`define EXV_OFF_CAUSE     8'h08
`define EXV_OFF_DBG       8'h0c
`define EXV_OFF_ISTAT     8'h10
`define EXV_OFF_IMASK     8'h14
`define EXV_OFF_IFLAG4    8'h18
`define EXV_OFF_IEN4      8'h1c
`define EXV_OFF_IPEND     8'h20
// ==================================================================
// reset values
`define EXV_RST_BASE      32'h8000_0000
`define EXV_RST_WORD      32'h0000_0000
// ==================================================================
// vectors
`define EXV_GEN_OFFSET    32'h0000_0180
`define EXV_DEBUG_VECTOR  32'hbfc0_0480
// ==================================================================
// cause codes
`define EXV_CC_LOAD_TRANSLATION_FAULT       5'h02
`define EXV_CC_STORE_TRANSLATION_FAULT       5'h03
`define EXV_CC_LOAD_ADDRESS_ERROR       5'h04
`define EXV_CC_STORE_ADDRESS_ERROR       5'h05
`define EXV_CC_DBE        5'h07
`define EXV_CC_SYSCALL    5'h08
`define EXV_CC_BREAK      5'h09
`define EXV_CC_RESV       5'h0a
`define EXV_CC_COPUN      5'h0b
`define EXV_CC_OVF        5'h0c
`define EXV_CC_TRAP       5'h0d
`define EXV_CC_WATCH      5'h17
// ==================================================================
// field positions
`define EXV_CTRL_EXL      0
`define EXV_DBG_LOAD      0
`define EXV_DBG_STORE     1
`define EXV_DBG_IMPR_LO   2
`define EXV_IST_GEN       0
`define EXV_IST_DBG       1
`define EXV_IST_IRQ4      2
// ==================================================================
// interrupt flag register 4
`define EXV_IRQ4_BASE     8'h80
`define EXV_IRQ4_PERSIST  32'h0fff_c032
`define EXV_BIT_PMP_ERR   1
`define EXV_BIT_I2C2_BUS  20
`define EXV_BIT_CAN1      23
`define EXV_MASK_I2C2     32'h0070_0000
`define EXV_MASK_CAN      32'h0180_0000
`endif

// File: verilog/exv_irq4.v
// interrupt flag and enable register 4 with persistence handling
`default_nettype none
`include "exv_regs.vh"

module exv_irq4 #(
  parameter        HAS_I2C2 = 1,
  parameter        HAS_CAN  = 1
) (
  input  wire        clk,
  input  wire        srst,
  input  wire [31:0] src_req,
  input  wire        flag_we,
  input  wire        en_we,
  input  wire [31:0] wdata,
  output reg  [31:0] flag_reg,
  output reg  [31:0] en_reg,
  output wire        req_any,
  output reg  [7:0]  pend_num
);
  // ================================================================
  // variant masks
  wire [31:0] impl = 32'hffff_ffff
                     & (HAS_I2C2 ? 32'hffff_ffff : ~`EXV_MASK_I2C2)   // RULE_14
                     & (HAS_CAN  ? 32'hffff_ffff : ~`EXV_MASK_CAN);
  wire [31:0] persist = `EXV_IRQ4_PERSIST;
  reg  [31:0] src_d_reg;
  wire [31:0] src  = src_req & impl;
  // persistent sources set the flag every cycle they stay high, so a
  // software clear only sticks once the source is gone; others latch an edge
  wire [31:0] set_v = (src & persist) | (src & ~src_d_reg & ~persist);   // RULE_16
  reg  [31:0] flag_next;
  wire [31:0] live = flag_reg & en_reg;
  integer     i;

  // ================================================================
  // flags: set wins over a software write in the same cycle
  always @* begin
    flag_next = flag_we ? (wdata & impl) : flag_reg;
    flag_next = flag_next | set_v;   // RULE_13 RULE_15
  end

  always @(posedge clk) begin
    if (srst) begin
      flag_reg  <= 32'h0000_0000;
      en_reg    <= 32'h0000_0000;
      src_d_reg <= 32'h0000_0000;
    end else begin
      flag_reg  <= flag_next;
      src_d_reg <= src;
      if (en_we)
        en_reg <= wdata & impl;   // RULE_13
    end
  end

  assign req_any = |live;

  // lowest pending bit wins; request number is base plus bit index
  always @* begin
    pend_num = 8'h00;
    for (i = 31; i >= 0; i = i - 1) begin
      if (live[i])
        pend_num = `EXV_IRQ4_BASE + i[7:0];
    end
  end
endmodule // exv_irq4
`default_nettype wire

// File: verilog/exv_top.v
// exception prioritisation, vectoring and interrupt flag register block
//
// Design decisions made here: the address map and strobed register access.
`default_nettype none
`include "exv_regs.vh"

// Functional notes
// RULE_01: simultaneous exceptions resolve by a fixed order, complex breakpoint last.
// RULE_02: coprocessor-unusable beats reserved instruction, codes 0x0b and 0x0a, general vector.
// RULE_03: execute exceptions go to base plus 0x180, set the level bit, codes 0x08 to 0x0c.
// RULE_04: a trap whose condition is true raises code 0x0d at the general vector.
// RULE_05: a data address break or store value break jumps to the debug vector, sets the matching debug bit, leaves the level bit.
// RULE_06: a watch register match raises code 0x17 at the general vector and sets the level bit.
// RULE_07: a misaligned or user-mode kernel load raises code 0x04.
// RULE_08: a misaligned or user-mode kernel store raises code 0x05.
// RULE_09: a load translation miss or invalid page raises code 0x02.
// RULE_10: a store translation miss or invalid page raises code 0x03.
// RULE_11: a data load or store bus error raises code 0x07 and sets the level bit.
// RULE_12: a load data compare break goes to the debug vector, sets the load break bit, writes no cause.
// RULE_13: port error source is request 129, flag and enable at bit 1 of register 4, persistent.
// RULE_14: second two-wire collision source is request 148, bit 20, persistent, larger variants only.
// RULE_15: first CAN source is request 151, bit 23, persistent.
// RULE_16: a persistent request stays while its source stays; others latch one event.
module exv_top #(
  parameter [4:0] CC_FPE      = `EXV_CC_OVF,
  parameter [4:0] CC_DSPDIS   = `EXV_CC_OVF,
  parameter       HAS_I2C2    = 1,
  parameter       HAS_CAN     = 1
) (
  input  wire        SYS_CLK,
  input  wire        SRST,
  // register port
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [31:0] REG_RDATA,
  // exception sources, sampled when EXC_VALID is high
  input  wire        EXC_VALID,
  input  wire        COP_UNUSABLE,
  input  wire        RESERVED_INSTR,
  input  wire        INT_OVERFLOW,
  input  wire        SYSCALL,
  input  wire        BREAK_INSTR,
  input  wire        FP_EXC,
  input  wire        DSP_DISABLED,
  input  wire        TRAP_TRUE,
  input  wire        DADDR_BRK_LOAD,
  input  wire        DADDR_BRK_STORE,
  input  wire        DVALUE_BRK_STORE,
  input  wire        WATCH_HIT,
  input  wire        LOAD_MISALIGN,
  input  wire        LOAD_USER_KERNEL,
  input  wire        STORE_MISALIGN,
  input  wire        STORE_USER_KERNEL,
  input  wire        LOAD_TLB_MISS,
  input  wire        LOAD_TLB_INVALID,
  input  wire        STORE_TLB_MISS,
  input  wire        STORE_TLB_INVALID,
  input  wire        DATA_BUS_ERROR,
  input  wire        LOAD_DATA_BRK,
  input  wire        COMPLEX_BREAKPOINT_HIT,
  input  wire [2:0]  COMPLEX_BREAKPOINT_IMPR,
  // exception result
  output reg         EXC_TAKEN,
  output reg  [31:0] EXC_VECTOR,
  output reg  [4:0]  EXC_CAUSE,
  output reg         EXC_DEBUG,
  output wire        EXCEPTION_LEVEL_BIT,
  output wire        LOAD_DATA_BREAK_FLAG,
  output wire        STORE_DATA_BREAK_FLAG,
  // peripheral interrupt sources of flag register 4
  input  wire [31:0] IRQ4_SRC,
  output wire        IRQ4_REQ,
  output wire [7:0]  IRQ4_NUM,
  output wire        IRQ
);
  // ================================================================
  // declarations
  localparam [2:0] K_NONE = 3'b001;
  localparam [2:0] K_GEN  = 3'b010;
  localparam [2:0] K_DBG  = 3'b100;

  reg  [31:0] base_reg;
  reg         exl_reg;
  reg  [31:0] cause_reg;
  reg  [4:0]  dbg_reg;
  reg  [2:0]  istat_reg;
  reg  [2:0]  imask_reg;
  reg  [2:0]  kind;
  reg  [4:0]  code;
  reg  [4:0]  dbg_set;
  reg  [4:0]  dbg_next;
  reg  [2:0]  istat_next;
  reg         exl_next;
  reg  [31:0] rdata_next;
  wire [31:0] flag4;
  wire [31:0] en4;
  wire [7:0]  pend4;
  wire        req4;
  reg         req4_d_reg;

  reg         taken_next;
  reg         debug_next;
  reg  [31:0] vector_next;
  reg  [4:0]  cause_next;
  reg  [4:0]  istat_wide;

  // ================================================================
  // register port decode and sticky-bit update, each used more than once
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // a hardware set beats a software clear in the same cycle
  function [4:0] w1c;
    input [4:0] cur;
    input       clr_en;
    input [4:0] clr;
    input [4:0] hw_set;
    begin
      w1c = (clr_en ? (cur & ~clr) : cur) | hw_set;
    end
  endfunction

  wire wr_base  = REG_WR && hit(REG_ADDR, `EXV_OFF_BASE);
  wire wr_ctrl  = REG_WR && hit(REG_ADDR, `EXV_OFF_CTRL);
  wire wr_dbg   = REG_WR && hit(REG_ADDR, `EXV_OFF_DBG);
  wire wr_istat = REG_WR && hit(REG_ADDR, `EXV_OFF_ISTAT);
  wire wr_imask = REG_WR && hit(REG_ADDR, `EXV_OFF_IMASK);
  wire wr_flag4 = REG_WR && hit(REG_ADDR, `EXV_OFF_IFLAG4);
  wire wr_en4   = REG_WR && hit(REG_ADDR, `EXV_OFF_IEN4);

  // ================================================================
  // conditions grouped as the priority list ranks them
  wire trap_exception          = TRAP_TRUE;
  wire addr_break_load         = DADDR_BRK_LOAD;
  wire store_break             = DADDR_BRK_STORE || DVALUE_BRK_STORE;
  wire watch_match             = WATCH_HIT;
  wire load_address_error      = LOAD_MISALIGN || LOAD_USER_KERNEL;
  wire store_address_error     = STORE_MISALIGN || STORE_USER_KERNEL;
  wire load_translation_fault  = LOAD_TLB_MISS || LOAD_TLB_INVALID;
  wire store_translation_fault = STORE_TLB_MISS || STORE_TLB_INVALID;
  wire data_bus_error          = DATA_BUS_ERROR;
  wire load_compare_break      = LOAD_DATA_BRK;
  wire complex_breakpoint      = COMPLEX_BREAKPOINT_HIT;

  // ================================================================
  // entry events that feed the interrupt status, in field order 2..0
  wire        gen_entry = (kind == K_GEN);
  wire        dbg_entry = (kind == K_DBG);
  wire        req4_rise = req4 & ~req4_d_reg;
  wire [2:0]  istat_set = {req4_rise, dbg_entry, gen_entry};

  // ================================================================
  // priority resolution, first match wins
  always @* begin
    kind    = K_NONE;
    code    = 5'h00;
    dbg_set = 5'h00;
    if (!EXC_VALID) begin
      kind = K_NONE;
    end else if (COP_UNUSABLE) begin   // RULE_01 RULE_02
      kind = K_GEN;
      code = `EXV_CC_COPUN;
    end else if (RESERVED_INSTR) begin   // RULE_02
      kind = K_GEN;
      code = `EXV_CC_RESV;
    end else if (INT_OVERFLOW) begin   // RULE_03
      kind = K_GEN;
      code = `EXV_CC_OVF;
    end else if (SYSCALL) begin   // RULE_03
      kind = K_GEN;
      code = `EXV_CC_SYSCALL;
    end else if (BREAK_INSTR) begin   // RULE_03
      kind = K_GEN;
      code = `EXV_CC_BREAK;
    end else if (FP_EXC) begin   // RULE_03
      kind = K_GEN;
      code = CC_FPE;
    end else if (DSP_DISABLED) begin   // RULE_03
      kind = K_GEN;
      code = CC_DSPDIS;
    end else if (trap_exception) begin   // RULE_04
      kind = K_GEN;
      code = `EXV_CC_TRAP;
    end else if (addr_break_load) begin   // RULE_05
      kind = K_DBG;
      dbg_set[`EXV_DBG_LOAD] = 1'b1;
    end else if (store_break) begin   // RULE_05
      kind = K_DBG;
      dbg_set[`EXV_DBG_STORE] = 1'b1;
    end else if (watch_match) begin   // RULE_06
      kind = K_GEN;
      code = `EXV_CC_WATCH;
    end else if (load_address_error) begin   // RULE_07
      kind = K_GEN;
      code = `EXV_CC_LOAD_ADDRESS_ERROR;
    end else if (store_address_error) begin   // RULE_08
      kind = K_GEN;
      code = `EXV_CC_STORE_ADDRESS_ERROR;
    end else if (load_translation_fault) begin   // RULE_09
      kind = K_GEN;
      code = `EXV_CC_LOAD_TRANSLATION_FAULT;
    end else if (store_translation_fault) begin   // RULE_10
      kind = K_GEN;
      code = `EXV_CC_STORE_TRANSLATION_FAULT;
    end else if (data_bus_error) begin   // RULE_11
      kind = K_GEN;
      code = `EXV_CC_DBE;
    end else if (load_compare_break) begin   // RULE_12
      kind = K_DBG;
      dbg_set[`EXV_DBG_LOAD] = 1'b1;
    end else if (complex_breakpoint) begin   // RULE_01
      kind = K_DBG;
      dbg_set[4:2] = COMPLEX_BREAKPOINT_IMPR;
    end
  end

  // ================================================================
  // next state of level bit, debug bits and interrupt status
  always @* begin
    exl_next = exl_reg;
    if (wr_ctrl)
      exl_next = REG_WDATA[`EXV_CTRL_EXL];
    // debug entries leave the level bit alone; hardware set beats software write
    case (kind)
      K_GEN:   exl_next = 1'b1;   // RULE_03 RULE_04 RULE_06 RULE_11
      K_DBG:   exl_next = exl_next;   // RULE_05
      K_NONE:  exl_next = exl_next;
      default: exl_next = exl_next;
    endcase
    dbg_next   = w1c(dbg_reg, wr_dbg, REG_WDATA[4:0], dbg_set);   // RULE_05 RULE_12
    istat_wide = w1c({2'b00, istat_reg}, wr_istat, {2'b00, REG_WDATA[2:0]}, {2'b00, istat_set});
    istat_next = istat_wide[2:0];
  end

  // ================================================================
  // next values of the entry outputs
  always @* begin
    taken_next  = gen_entry | dbg_entry;
    debug_next  = dbg_entry;
    vector_next = EXC_VECTOR;
    cause_next  = EXC_CAUSE;
    case (kind)
      K_GEN: begin
        // general entry: common handler past the base
        vector_next = base_reg + `EXV_GEN_OFFSET;   // RULE_03
        cause_next  = code;
      end
      K_DBG: begin
        // the cause code is left untouched on debug entry
        vector_next = `EXV_DEBUG_VECTOR;   // RULE_05 RULE_12
      end
      K_NONE: begin
        vector_next = EXC_VECTOR;
      end
      default: begin
        vector_next = EXC_VECTOR;
      end
    endcase
  end

  // ================================================================
  // sequential state
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      base_reg   <= `EXV_RST_BASE;
      exl_reg    <= 1'b0;
      cause_reg  <= `EXV_RST_WORD;
      dbg_reg    <= 5'h00;
      istat_reg  <= 3'h0;
      imask_reg  <= 3'h0;
      req4_d_reg <= 1'b0;
      EXC_TAKEN  <= 1'b0;
      EXC_VECTOR <= `EXV_RST_WORD;
      EXC_CAUSE  <= 5'h00;
      EXC_DEBUG  <= 1'b0;
      REG_RDATA  <= `EXV_RST_WORD;
    end else begin
      exl_reg    <= exl_next;
      dbg_reg    <= dbg_next;
      istat_reg  <= istat_next;
      req4_d_reg <= req4;
      REG_RDATA  <= rdata_next;
      if (wr_base)
        base_reg <= {REG_WDATA[31:12], 12'h000};
      if (wr_imask)
        imask_reg <= REG_WDATA[2:0];
      EXC_TAKEN  <= taken_next;
      EXC_DEBUG  <= debug_next;
      EXC_VECTOR <= vector_next;
      EXC_CAUSE  <= cause_next;
      cause_reg  <= {27'h0, cause_next};
    end
  end

  // ================================================================
  // register read, unmapped addresses read zero
  always @* begin
    rdata_next = `EXV_RST_WORD;
    if (REG_RD) begin
      case (REG_ADDR)
        `EXV_OFF_BASE:   rdata_next = base_reg;
        `EXV_OFF_CTRL:   rdata_next = {31'h0, exl_reg};
        `EXV_OFF_CAUSE:  rdata_next = cause_reg;
        `EXV_OFF_DBG:    rdata_next = {27'h0, dbg_reg};
        `EXV_OFF_ISTAT:  rdata_next = {29'h0, istat_reg};
        `EXV_OFF_IMASK:  rdata_next = {29'h0, imask_reg};
        `EXV_OFF_IFLAG4: rdata_next = flag4;
        `EXV_OFF_IEN4:   rdata_next = en4;
        `EXV_OFF_IPEND:  rdata_next = {23'h0, req4, pend4};
        default:         rdata_next = `EXV_RST_WORD;
      endcase
    end
  end

  // ================================================================
  // interrupt flag register 4
  exv_irq4 #(
    .HAS_I2C2 (HAS_I2C2),
    .HAS_CAN  (HAS_CAN)
  ) u_irq4 (
    .clk      (SYS_CLK),
    .srst     (SRST),
    .src_req  (IRQ4_SRC),
    .flag_we  (wr_flag4),
    .en_we    (wr_en4),
    .wdata    (REG_WDATA),
    .flag_reg (flag4),
    .en_reg   (en4),
    .req_any  (req4),
    .pend_num (pend4)
  );

  // ================================================================
  // output taps
  assign EXCEPTION_LEVEL_BIT   = exl_reg;
  assign LOAD_DATA_BREAK_FLAG  = dbg_reg[`EXV_DBG_LOAD];
  assign STORE_DATA_BREAK_FLAG = dbg_reg[`EXV_DBG_STORE];
  assign IRQ4_REQ              = req4;
  assign IRQ4_NUM              = pend4;
  assign IRQ                   = |(istat_reg & imask_reg);
endmodule // exv_top
`default_nettype wire

// File: verif/exv_core_mdl.sv
// core pipeline stand-in that presents exception flags to the block
`default_nettype none
module exv_core_mdl (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [22:0] cond_in,
  output var  logic        valid,
  output var  logic [22:0] cond
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid = 1'b0;
    cond  = 23'h000000;
  end
  // outside a valid cycle the flags carry junk, so a block that ignores valid is caught
  always @(posedge clk) begin
    valid <= go;
    cond  <= go ? cond_in : ~cond;
  end
endmodule // exv_core_mdl
`default_nettype wire

// File: verif/exv_top_chk.sv
// concurrent checks on the ports of the exception vectoring block
`default_nettype none
module exv_top_chk (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        REG_WR,
  input wire logic        EXC_VALID,
  input wire logic        COP_UNUSABLE,
  input wire logic        RESERVED_INSTR,
  input wire logic        INT_OVERFLOW,
  input wire logic        COMPLEX_BREAKPOINT_HIT,
  input wire logic        EXC_TAKEN,
  input wire logic [31:0] EXC_VECTOR,
  input wire logic [4:0]  EXC_CAUSE,
  input wire logic        EXC_DEBUG,
  input wire logic        EXCEPTION_LEVEL_BIT,
  input wire logic        STORE_DATA_BREAK_FLAG,
  input wire logic        IRQ4_REQ,
  input wire logic [7:0]  IRQ4_NUM
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // ==================================================================
  // exception entry
  property p_idle; !EXC_VALID |=> !EXC_TAKEN; endproperty
  a_idle: assert property (p_idle) else $error("entry without valid");
  property p_complex_breakpoint; EXC_VALID && COMPLEX_BREAKPOINT_HIT |=> EXC_TAKEN; endproperty
  a_complex_breakpoint: assert property (p_complex_breakpoint) else $error("lowest source not taken");
  property p_cop;
    EXC_VALID && COP_UNUSABLE |=> !EXC_DEBUG && EXC_CAUSE == 5'h0b;
  endproperty
  a_cop: assert property (p_cop) else $error("unusable cause wrong");
  property p_resv;
    EXC_VALID && RESERVED_INSTR && !COP_UNUSABLE |=> EXC_CAUSE == 5'h0a;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved cause wrong");
  property p_ovf;
    EXC_VALID && INT_OVERFLOW && !COP_UNUSABLE && !RESERVED_INSTR
      |=> EXC_CAUSE == 5'h0c && EXCEPTION_LEVEL_BIT;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow entry wrong");
  property p_gen;
    EXC_TAKEN && !EXC_DEBUG |-> EXC_VECTOR[11:0] == 12'h180 && EXCEPTION_LEVEL_BIT;
  endproperty
  a_gen: assert property (p_gen) else $error("general vector wrong");
  property p_dbg;
    EXC_DEBUG |-> EXC_TAKEN && EXC_VECTOR == 32'hbfc0_0480 && $stable(EXC_CAUSE);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug entry wrong");
  property p_dlvl;
    EXC_DEBUG && !$past(REG_WR) |-> $stable(EXCEPTION_LEVEL_BIT);
  endproperty
  a_dlvl: assert property (p_dlvl) else $error("debug moved level bit");
  property p_st; $rose(STORE_DATA_BREAK_FLAG) |-> EXC_DEBUG; endproperty
  a_st: assert property (p_st) else $error("store break flag without entry");
  // ==================================================================
  // flag register 4 request number
  property p_num;
    IRQ4_REQ ? IRQ4_NUM[7:5] == 3'b100 : IRQ4_NUM == 8'h00;
  endproperty
  a_num: assert property (p_num) else $error("request number wrong");
endmodule // exv_top_chk
bind exv_top exv_top_chk u_exv_top_chk (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WR(REG_WR),
  .EXC_VALID(EXC_VALID), .COP_UNUSABLE(COP_UNUSABLE), .RESERVED_INSTR(RESERVED_INSTR),
  .INT_OVERFLOW(INT_OVERFLOW), .COMPLEX_BREAKPOINT_HIT(COMPLEX_BREAKPOINT_HIT), .EXC_TAKEN(EXC_TAKEN),
  .EXC_VECTOR(EXC_VECTOR), .EXC_CAUSE(EXC_CAUSE), .EXC_DEBUG(EXC_DEBUG),
  .EXCEPTION_LEVEL_BIT(EXCEPTION_LEVEL_BIT), .STORE_DATA_BREAK_FLAG(STORE_DATA_BREAK_FLAG),
  .IRQ4_REQ(IRQ4_REQ), .IRQ4_NUM(IRQ4_NUM));
`default_nettype wire

// File: verif/tb_exv_top.sv
// self-checking bench for the exception vectoring block
`default_nettype none
module tb_exv_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0]  CC[23] = '{5'h0b, 5'h0a, 5'h0c, 5'h08, 5'h09, 5'h0c, 5'h0c, 5'h0d,
    5'h00, 5'h00, 5'h00, 5'h17, 5'h04, 5'h04, 5'h05, 5'h05, 5'h02, 5'h02, 5'h03, 5'h03,
    5'h07, 5'h00, 5'h00};
  localparam logic [22:0] DBGM    = 23'h600700;
  localparam int          BITS[3] = '{1, 20, 23};
  localparam int          NUMS[3] = '{129, 148, 151};
  logic        SYS_CLK, SRST, REG_WR, REG_RD, go, rd_q;
  logic [7:0]  REG_ADDR;
  logic [31:0] REG_WDATA, IRQ4_SRC, base_e, x;
  logic [22:0] cond_in;
  logic [4:0]  cause_e;
  logic [2:0]  COMPLEX_BREAKPOINT_IMPR;
  wire  [31:0] REG_RDATA, EXC_VECTOR;
  wire  [22:0] c;
  wire  [4:0]  EXC_CAUSE;
  wire  [7:0]  IRQ4_NUM;
  wire         v, EXC_TAKEN, EXC_DEBUG, IRQ, lbrk;
  logic [37:0] eq[$];
  logic [31:0] rq[$];
  int          n_mismatch, n_tests, cyc, seed;

  exv_core_mdl u_exv_core_mdl (.clk(SYS_CLK), .go(go), .cond_in(cond_in), .valid(v), .cond(c));
  exv_top u_exv_top (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .EXC_VALID(v), .COP_UNUSABLE(c[0]), .RESERVED_INSTR(c[1]), .INT_OVERFLOW(c[2]),
    .SYSCALL(c[3]), .BREAK_INSTR(c[4]), .FP_EXC(c[5]), .DSP_DISABLED(c[6]), .TRAP_TRUE(c[7]),
    .DADDR_BRK_LOAD(c[8]), .DADDR_BRK_STORE(c[9]), .DVALUE_BRK_STORE(c[10]),
    .WATCH_HIT(c[11]), .LOAD_MISALIGN(c[12]), .LOAD_USER_KERNEL(c[13]),
    .STORE_MISALIGN(c[14]), .STORE_USER_KERNEL(c[15]), .LOAD_TLB_MISS(c[16]),
    .LOAD_TLB_INVALID(c[17]), .STORE_TLB_MISS(c[18]), .STORE_TLB_INVALID(c[19]),
    .DATA_BUS_ERROR(c[20]), .LOAD_DATA_BRK(c[21]), .COMPLEX_BREAKPOINT_HIT(c[22]), .COMPLEX_BREAKPOINT_IMPR(COMPLEX_BREAKPOINT_IMPR),
    .EXC_TAKEN(EXC_TAKEN), .EXC_VECTOR(EXC_VECTOR), .EXC_CAUSE(EXC_CAUSE),
    .EXC_DEBUG(EXC_DEBUG), .EXCEPTION_LEVEL_BIT(), .LOAD_DATA_BREAK_FLAG(lbrk),
    .STORE_DATA_BREAK_FLAG(), .IRQ4_SRC(IRQ4_SRC), .IRQ4_REQ(), .IRQ4_NUM(IRQ4_NUM), .IRQ(IRQ));

  // ==================================================================
  // shared tasks
  task automatic cmp(input string nm, input logic [37:0] e, input logic [37:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    if (eq.size() + rq.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a spare edge after each access keeps a strobe from being lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic exc(input logic [22:0] m);
    int w;
    w = 0;
    while (!m[w]) w++;
    if (!DBGM[w]) cause_e = CC[w];
    eq.push_back({DBGM[w], DBGM[w] ? 32'hbfc0_0480 : base_e + 32'h180, cause_e});
    cond_in <= m;
    go <= 1'b1;
    @(posedge SYS_CLK);
  endtask

  // ==================================================================
  // result watcher and hang limit
  always @(posedge SYS_CLK) begin
    rd_q <= REG_RD;
    cyc <= cyc + 1;
    if (rd_q) cmp("rdata", rq.pop_front(), REG_RDATA);
    if (EXC_TAKEN === 1'b1) cmp("exc", eq.pop_front(), {EXC_DEBUG, EXC_VECTOR, EXC_CAUSE});
    if (cyc == 4000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    {SRST, REG_WR, REG_RD, go, rd_q} = 5'b10000;
    {REG_ADDR, REG_WDATA, IRQ4_SRC, cond_in} = '0;
    COMPLEX_BREAKPOINT_IMPR = 3'h5;
    cause_e = 5'h00;
    seed = 32'h055a;
    repeat (12) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rd(8'h00, 32'h8000_0000);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h1234_5678);
    rd(8'h00, 32'h1234_5000);
    base_e = 32'h1234_5000;
    wr(8'h14, 32'h1);
    for (int i = 0; i < 12; i++) exc(1 << i);
    for (int i = 12; i < 23; i++) exc(1 << i);
    go <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    rd(8'h04, 32'h1);
    rd(8'h0c, 32'h17);
    cmp("ldbrk", 1'b1, lbrk);
    cmp("irq", 1'b1, IRQ);
    wr(8'h10, 32'h1);
    cmp("irq", 1'b0, IRQ);
    wr(8'h04, 32'h0);
    exc(23'h000400);
    go <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    rd(8'h04, 32'h0);
    repeat (200) begin
      x = $random(seed) & $random(seed);
      COMPLEX_BREAKPOINT_IMPR <= x[30:28];
      exc(23'(x >> x[27:24]) | 23'h400000);
    end
    go <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    wr(8'h14, 32'h4);
    for (int k = 0; k < 3; k++) begin
      wr(8'h1c, 32'h1 << BITS[k]);
      IRQ4_SRC <= 32'h1 << BITS[k];
      wr(8'h18, 32'h0);
      rd(8'h20, 32'h100 + NUMS[k]);
      rd(8'h18, 32'h1 << BITS[k]);
      IRQ4_SRC <= 32'h0;
      wr(8'h18, 32'h0);
      rd(8'h18, 32'h0);
    end
    cmp("irq", 1'b1, IRQ);
    wr(8'h10, 32'h4);
    cmp("irq", 1'b0, IRQ);
    IRQ4_SRC <= 32'h4;
    @(posedge SYS_CLK);
    IRQ4_SRC <= 32'h0;
    rd(8'h18, 32'h4);
    // let the watcher take the last read before the queues are checked
    repeat (2) @(posedge SYS_CLK);
    test_done();
  end
endmodule // tb_exv_top
`default_nettype wire
